/* hdl/uart_control_and_data_regs.sv */
// Serial unit: APB register file, baud generator, transmitter and receiver
module uart_control_and_data_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock gating state of the unit
   input wire logic uart_clock_stopped,
   // Serial pins
   output logic transmit_pin_out,
   output logic transmit_pin_oe_n,
   input wire logic receive_shared_pin_in,
   output logic receive_shared_pin_out,
   output logic receive_shared_pin_oe_n,
   // Requests
   output logic serial_interrupt_request,
   output logic wake_request
);
   logic [7:0] frame_r, frame_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic single_wire_r;
   logic mode_r;
   logic [7:0] divider_r;
   logic [7:0] rx_data_r;
   logic [7:0] tx_hold_r;
   logic tx_hold9_r;
   logic irq_r, wake_r;
   logic tx_empty_r, tx_idle_r, rx_avail_r, overrun_r, ferr_r, perr_r, noise_r;
   logic status_seen_r;
   logic [7:0] seen_r;
   logic rx_load, rx_idle;
   logic [9:0] rx_bits_r;

   wire wr = psel && penable && pwrite;
   wire rd = psel && penable && !pwrite;
   wire sel_frame = (paddr == uart_pkg::off_frame_control);
   wire sel_ctrl = (paddr == uart_pkg::off_enable_interrupt_control);
   wire sel_sw = (paddr == uart_pkg::off_single_wire_control);
   wire sel_data = (paddr == uart_pkg::off_data_buffer);
   wire sel_stat = (paddr == uart_pkg::off_status);
   wire sel_div = (paddr == uart_pkg::off_baud_divider);
   wire sel_sc = (paddr == uart_pkg::off_serial_control);
   wire mapped = sel_frame || sel_ctrl || sel_sw || sel_data || sel_stat || sel_div || sel_sc;

   wire func_en = frame_r[uart_pkg::fc_function_enable];
   wire nine = frame_r[uart_pkg::fc_data_length];
   wire par_en = frame_r[uart_pkg::fc_parity_enable];
   wire par_odd = frame_r[uart_pkg::fc_parity_type];
   wire two_stop = frame_r[uart_pkg::fc_stop_bits];
   wire brk = frame_r[uart_pkg::fc_send_break];
   wire active = mode_r && func_en;
   wire tx_run = active && ctrl_r[uart_pkg::ec_tx_enable];
   wire rx_run = active && ctrl_r[uart_pkg::ec_rx_enable];

   // Status snapshot so clear sequences only hit flags software saw
   wire [7:0] status = {perr_r, noise_r, ferr_r, overrun_r, rx_idle, rx_avail_r,
                        tx_idle_r, tx_empty_r};
   wire data_rd = rd && sel_data && status_seen_r;
   wire data_wr = wr && sel_data;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Frame control: ninth rx bit is read-only, break cleared by disable
   always_comb begin
      frame_nxt = frame_r;
      if (wr && sel_frame) begin
         frame_nxt = {pwdata[7:2], frame_r[uart_pkg::fc_rx_ninth], pwdata[0]};
      end
      if (!frame_nxt[uart_pkg::fc_function_enable]) begin
         frame_nxt[uart_pkg::fc_send_break] = 1'b0;
      end
      if (rx_load) begin
         frame_nxt[uart_pkg::fc_rx_ninth] = rx_bits_r[8];
      end
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr && sel_ctrl) begin
         ctrl_nxt = pwdata[7:0];
      end
      if (!frame_nxt[uart_pkg::fc_function_enable]) begin
         ctrl_nxt[uart_pkg::ec_tx_enable] = 1'b0;
         ctrl_nxt[uart_pkg::ec_rx_enable] = 1'b0;
      end
   end

   // Other control bits keep their values over disable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frame_r <= uart_pkg::frame_control_reset;
         ctrl_r <= uart_pkg::enable_interrupt_reset;
         single_wire_r <= 1'b0;
         mode_r <= 1'b0;
         divider_r <= uart_pkg::baud_divider_reset;
      end else begin
         frame_r <= frame_nxt;
         ctrl_r <= ctrl_nxt;
         if (wr && sel_sw) begin
            single_wire_r <= pwdata[0];
         end
         if (wr && sel_sc) begin
            mode_r <= pwdata[uart_pkg::sc_mode_select];
         end
         if (wr && sel_div) begin
            divider_r <= pwdata[7:0];
         end
      end
   end

   // Read mux; write-only ninth tx bit and unused bits read zero
   wire [7:0] rd_byte = sel_frame ? {frame_r[7:1], 1'b0} :
                        sel_ctrl ? ctrl_r :
                        sel_sw ? {7'h00, single_wire_r} :
                        sel_data ? rx_data_r :
                        sel_stat ? status :
                        sel_div ? divider_r :
                        sel_sc ? {3'h0, mode_r, 2'h0, wake_r, irq_r} : 8'h00;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rd_byte};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_seen_r <= 1'b0;
         seen_r <= 8'h00;
      end else if (rd && sel_stat) begin
         status_seen_r <= 1'b1;
         seen_r <= status;
      end else if (psel && penable && sel_data) begin
         status_seen_r <= 1'b0;
      end
   end

   // Baud tick: 16 ticks per bit, tick every (N+1) or 4(N+1) clocks
   logic [9:0] baud_cnt_r;
   wire [9:0] div_n1 = {2'h0, divider_r} + 10'h001;
   wire [9:0] tick_period = ctrl_r[uart_pkg::ec_baud_speed] ? div_n1 :
                            10'((div_n1 * uart_pkg::low_speed_factor));
   wire tick = (baud_cnt_r >= tick_period - 10'h001);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         baud_cnt_r <= 10'h000;
      end else if (!active || tick) begin
         baud_cnt_r <= 10'h000;
      end else begin
         baud_cnt_r <= baud_cnt_r + 10'h001;
      end
   end

   // Transmitter
   typedef enum logic [1:0] {tx_off, tx_wait, tx_shift, tx_break} tx_state_e;
   tx_state_e tx_state_r;
   logic [12:0] tx_sr_r;
   logic [3:0] tx_left_r;
   logic [3:0] tx_phase_r;
   logic [4:0] brk_cnt_r;
   wire [8:0] tx_word = {tx_hold9_r & nine, tx_hold_r};
   wire tx_par = (nine ? ^tx_word : ^tx_hold_r) ^ par_odd;
   // Frame LSB first after start bit; unused high bits are idle ones
   wire [12:0] frame8 = par_en ? {3'h7, tx_par, tx_hold_r, 1'b0} : {4'hf, tx_hold_r, 1'b0};
   wire [12:0] frame9 = par_en ? {2'h3, tx_par, tx_word, 1'b0} : {3'h7, tx_word, 1'b0};
   wire [3:0] tx_len = 4'ha + {3'h0, nine} + {3'h0, par_en} + {3'h0, two_stop};
   wire bit_end = tick && (tx_phase_r == uart_pkg::oversample_last);
   wire tx_start = (tx_state_r == tx_wait) && !tx_empty_r;
   wire tx_done = (tx_state_r == tx_shift) && bit_end && (tx_left_r == 4'h1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_state_r <= tx_off;
         tx_sr_r <= 13'h1fff;
         tx_left_r <= 4'h0;
         tx_phase_r <= 4'h0;
         brk_cnt_r <= 5'h00;
      end else if (!tx_run) begin
         tx_state_r <= tx_off;
         tx_sr_r <= 13'h1fff;
         tx_phase_r <= 4'h0;
         tx_left_r <= 4'h0;
         brk_cnt_r <= 5'h00;
      end else begin
         if (tick) begin
            tx_phase_r <= tx_phase_r + 4'h1;
         end
         case (tx_state_r)
            tx_off: begin
               tx_state_r <= tx_wait;
            end
            tx_wait: begin
               tx_phase_r <= 4'h0;
               if (tx_start) begin
                  tx_state_r <= tx_shift;
                  tx_sr_r <= nine ? frame9 : frame8;
                  tx_left_r <= tx_len;
               end else if (brk) begin
                  tx_state_r <= tx_break;
                  brk_cnt_r <= 5'h00;
               end
            end
            tx_shift: begin
               if (bit_end) begin
                  tx_sr_r <= {1'b1, tx_sr_r[12:1]};
                  tx_left_r <= tx_left_r - 4'h1;
                  if (tx_done) begin
                     tx_state_r <= tx_wait;
                  end
               end
            end
            tx_break: begin
               if (bit_end && brk_cnt_r != uart_pkg::break_bits) begin
                  brk_cnt_r <= brk_cnt_r + 5'h01;
               end
               if (!brk && brk_cnt_r == uart_pkg::break_bits) begin
                  tx_state_r <= tx_wait;
               end
            end
            default: begin
               tx_state_r <= tx_off;
            end
         endcase
      end
   end
   wire tx_line = (tx_state_r == tx_break) ? 1'b0 : tx_sr_r[0];

   // Receiver: two-stage synchroniser, three-sample majority at mid bit
   logic rx_s1_r, rx_s2_r, rx_prev_r;
   logic rx_busy_r;
   logic [3:0] rx_phase_r, rx_idx_r;
   logic [1:0] rx_smp_r;
   logic rx_noisy_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         rx_s1_r <= receive_shared_pin_in;
         rx_s2_r <= rx_s1_r;
         rx_prev_r <= rx_s2_r;
      end
   end
   assign rx_idle = !rx_busy_r;
   wire [3:0] rx_nbits = 4'h8 + {3'h0, nine} + {3'h0, par_en};
   wire maj = (rx_smp_r[1] & rx_smp_r[0]) | (rx_smp_r[1] & rx_s2_r) | (rx_smp_r[0] & rx_s2_r);
   wire bad = !(rx_smp_r[1] == rx_smp_r[0] && rx_smp_r[0] == rx_s2_r);
   wire rx_sample = rx_busy_r && tick && (rx_phase_r == uart_pkg::sample_mid);
   wire rx_stop = rx_sample && (rx_idx_r == rx_nbits + 4'h1);
   wire [8:0] rx_word = nine ? rx_bits_r[8:0] : {1'b0, rx_bits_r[7:0]};
   wire rx_par_bit = nine ? rx_bits_r[9] : rx_bits_r[8];
   wire rx_par_bad = par_en && ((^rx_word ^ par_odd) != rx_par_bit);
   wire addr_bit = nine ? rx_bits_r[8] : rx_bits_r[7];
   wire rx_keep = !ctrl_r[uart_pkg::ec_address_detect] || addr_bit;
   assign rx_load = rx_stop && rx_keep && !rx_avail_r;
   wire rx_over = rx_stop && rx_keep && rx_avail_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_busy_r <= 1'b0;
         rx_phase_r <= 4'h0;
         rx_idx_r <= 4'h0;
         rx_bits_r <= 10'h000;
         rx_smp_r <= 2'h3;
         rx_noisy_r <= 1'b0;
      end else if (!rx_run) begin
         rx_busy_r <= 1'b0;
         rx_phase_r <= 4'h0;
         rx_idx_r <= 4'h0;
         rx_noisy_r <= 1'b0;
      end else if (!rx_busy_r) begin
         rx_phase_r <= 4'h0;
         rx_idx_r <= 4'h0;
         rx_noisy_r <= 1'b0;
         if (rx_prev_r && !rx_s2_r) begin
            rx_busy_r <= 1'b1;
         end
      end else if (tick) begin
         rx_phase_r <= rx_phase_r + 4'h1;
         rx_smp_r <= {rx_smp_r[0], rx_s2_r};
         if (rx_sample) begin
            rx_noisy_r <= rx_noisy_r | bad;
            if (rx_idx_r == 4'h0 && maj) begin
               rx_busy_r <= 1'b0; // False start
            end else if (rx_stop) begin
               rx_busy_r <= 1'b0;
            end else begin
               rx_idx_r <= rx_idx_r + 4'h1;
               if (rx_idx_r != 4'h0) begin
                  rx_bits_r[rx_idx_r - 4'h1] <= maj;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_data_r <= 8'h00;
      end else if (rx_load) begin
         rx_data_r <= rx_word[7:0];
      end
   end

   // Flags: hardware set wins over the software clear sequence
   wire stop_bad = rx_stop && !maj;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {perr_r, noise_r, ferr_r, overrun_r, rx_avail_r} <= 5'h00;
         tx_empty_r <= 1'b1;
         tx_idle_r <= 1'b1;
         tx_hold_r <= 8'h00;
         tx_hold9_r <= 1'b0;
      end else if (!func_en) begin
         {perr_r, noise_r, ferr_r, overrun_r, rx_avail_r} <= 5'h00;
         tx_empty_r <= 1'b1;
         tx_idle_r <= 1'b1;
      end else begin
         if (data_wr) begin
            tx_hold_r <= pwdata[7:0];
            tx_hold9_r <= frame_r[uart_pkg::fc_tx_ninth];
         end
         if (!tx_run) begin
            tx_empty_r <= 1'b1;
         end else if (tx_start) begin
            tx_empty_r <= 1'b1;
         end else if (data_wr) begin
            tx_empty_r <= 1'b0;
         end
         if (tx_start || (tx_state_r == tx_break) || (data_wr && tx_run)) begin
            tx_idle_r <= 1'b0;
         end else if (tx_state_r == tx_wait && tx_empty_r) begin
            tx_idle_r <= 1'b1;
         end
         if (!rx_run) begin
            {perr_r, noise_r, ferr_r, overrun_r, rx_avail_r} <= 5'h00;
         end else if (rx_load) begin
            rx_avail_r <= 1'b1;
            perr_r <= rx_par_bad;
            ferr_r <= stop_bad;
            noise_r <= rx_noisy_r | bad;
         end else if (rx_over) begin
            overrun_r <= 1'b1;
         end else if (data_rd) begin
            rx_avail_r <= rx_avail_r & ~seen_r[2];
            overrun_r <= overrun_r & ~seen_r[4];
            ferr_r <= ferr_r & ~seen_r[5];
            noise_r <= noise_r & ~seen_r[6];
            perr_r <= perr_r & ~seen_r[7];
         end
      end
   end

   // Shared request: sticky, cleared by writing one
   logic tx_idle_d_r, tx_empty_d_r;
   wire pin_fall = rx_prev_r && !rx_s2_r;
   wire wake_ev = ctrl_r[uart_pkg::ec_pin_wake] && uart_clock_stopped && pin_fall;
   wire irq_ev = (ctrl_r[uart_pkg::ec_rx_ie] && (rx_load || rx_over)) ||
                 (ctrl_r[uart_pkg::ec_tx_idle_ie] && tx_idle_r && !tx_idle_d_r) ||
                 (ctrl_r[uart_pkg::ec_tx_empty_ie] && tx_empty_r && !tx_empty_d_r) ||
                 wake_ev;
   wire sc_clr = wr && sel_sc;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_r <= 1'b0;
         wake_r <= 1'b0;
         tx_idle_d_r <= 1'b1;
         tx_empty_d_r <= 1'b1;
      end else begin
         tx_idle_d_r <= tx_idle_r;
         tx_empty_d_r <= tx_empty_r;
         if (irq_ev) begin
            irq_r <= 1'b1;
         end else if (sc_clr && pwdata[uart_pkg::sc_request]) begin
            irq_r <= 1'b0;
         end
         if (wake_ev) begin
            wake_r <= 1'b1;
         end else if (sc_clr && pwdata[uart_pkg::sc_wake]) begin
            wake_r <= 1'b0;
         end
      end
   end
   assign serial_interrupt_request = irq_r;
   assign wake_request = wake_r;

   // Pins: single-wire sends on the shared pin only when receive is off
   wire sw_tx = single_wire_r && !ctrl_r[uart_pkg::ec_rx_enable];
   assign transmit_pin_out = tx_line;
   assign transmit_pin_oe_n = !(tx_run && !single_wire_r);
   assign receive_shared_pin_out = tx_line;
   assign receive_shared_pin_oe_n = !(tx_run && sw_tx);
endmodule : uart_control_and_data_regs

/* common/uart_pkg.sv */
// Register map, field positions, reset values and counts of the serial unit
// Function
// - Disable empties the character buffer and restarts the baud counter.
// - Disable clears enables, break and receive flags; sets both idle and empty flags.
// - Disable keeps all other control bits and the divider for re-enable.
// - Clearing function enable mid-transfer stops both directions at once.
// - Length select gives 8 or 9 data bits; ninth bits in dedicated fields.
// - Parity enable turns parity on; type selects even (0) or odd (1).
// - Stop select sends one stop bit (0) or two (1).
// - Break drives the line low at least 13 bit times until cleared.
// - Clearing transmit enable aborts, resets the transmitter, floats its pin.
// - Transmitter runs only with mode select, function enable, transmit enable.
// - Clearing receive enable aborts, resets the receiver; with single-wire and transmit on, the shared pin then sends.
// - Receiver runs only with mode select, function enable, receive enable.
// - Speed select picks divide by 64 (0) or 16 (1) with divider.
// - Address detect keeps words with address bit set and may interrupt.
// - Address detect drops words with address bit clear, no interrupt.
// - Pin falling edge wakes only with wake enable and unit clock stopped.
// - Receive interrupt enable lets overrun or data available set the request.
// - Idle interrupt enable lets transmitter idle set the request.
// - Empty interrupt enable lets transmitter empty set the request.
// - Single-wire off: shared pin receives only; on: role follows enables.
// - Single-wire with both enables set: shared pin only receives.
// - Data register writes transmit data, reads received data; unused bits zero.
// - Mode select bit chooses UART operation when 1.
// - Function enable low floats both serial pins.
// - NRZ frame: start, data LSB first, parity, stops; receiver checks one stop.
package uart_pkg;
   localparam logic [7:0] off_frame_control = 8'h00;
   localparam logic [7:0] off_enable_interrupt_control = 8'h04;
   localparam logic [7:0] off_single_wire_control = 8'h08;
   localparam logic [7:0] off_data_buffer = 8'h0c;
   localparam logic [7:0] off_status = 8'h10;
   localparam logic [7:0] off_baud_divider = 8'h14;
   localparam logic [7:0] off_serial_control = 8'h18;
   // Frame control fields
   localparam int fc_function_enable = 7;
   localparam int fc_data_length = 6;
   localparam int fc_parity_enable = 5;
   localparam int fc_parity_type = 4;
   localparam int fc_stop_bits = 3;
   localparam int fc_send_break = 2;
   localparam int fc_rx_ninth = 1;
   localparam int fc_tx_ninth = 0;
   // Enable and interrupt control fields
   localparam int ec_tx_enable = 7;
   localparam int ec_rx_enable = 6;
   localparam int ec_baud_speed = 5;
   localparam int ec_address_detect = 4;
   localparam int ec_pin_wake = 3;
   localparam int ec_rx_ie = 2;
   localparam int ec_tx_idle_ie = 1;
   localparam int ec_tx_empty_ie = 0;
   // Serial control fields
   localparam int sc_mode_select = 4;
   localparam int sc_request = 0;
   localparam int sc_wake = 1;
   // Status reset value: rx idle, tx idle, tx empty
   localparam logic [7:0] status_reset = 8'h0b;
   localparam logic [7:0] frame_control_reset = 8'h00;
   localparam logic [7:0] enable_interrupt_reset = 8'h00;
   localparam logic [7:0] baud_divider_reset = 8'h00;
   // Baud timing
   localparam logic [3:0] oversample_last = 4'hf;
   localparam logic [3:0] sample_mid = 4'h9;
   localparam logic [4:0] break_bits = 5'h0d;
   localparam logic [9:0] low_speed_factor = 10'h004;
endpackage : uart_pkg

/* verif/uart_regs_sva.sv */
// Port-level checker of the serial unit
module uart_regs_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and requests
   input wire logic uart_clock_stopped,
   input wire logic transmit_pin_out,
   input wire logic transmit_pin_oe_n,
   input wire logic receive_shared_pin_in,
   input wire logic receive_shared_pin_out,
   input wire logic receive_shared_pin_oe_n,
   input wire logic serial_interrupt_request,
   input wire logic wake_request
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [3:0] run_r;
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire mapped = paddr <= 8'h18 && paddr[1:0] == 2'b00;
   wire irq_clr = wr && paddr == 8'h18 && pwdata[0];
   wire wake_clr = wr && paddr == 8'h18 && pwdata[1];
   // Request register delay lets an edge seen while stopped rise just after restart
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) run_r <= 4'h0;
      else if (uart_clock_stopped) run_r <= 4'h0;
      else if (run_r != 4'hf) run_r <= run_r + 4'h1;
   end
   sequence s_off_wr;
      wr && paddr == 8'h00 && !pwdata[7];
   endsequence
   sequence s_both_wr;
      wr && paddr == 8'h04 && pwdata[7:6] == 2'b11;
   endsequence
   AST_OFF_FLOAT: assert property (s_off_wr |=> (transmit_pin_oe_n && receive_shared_pin_oe_n) [*2])
      else $error("pins driven after disable");
   AST_SW_BOTH: assert property (s_both_wr |=> receive_shared_pin_oe_n)
      else $error("shared pin driven with both enables");
   AST_IRQ_HOLD: assert property ($fell(serial_interrupt_request) |-> $past(irq_clr))
      else $error("request dropped without clear");
   AST_WAKE_HOLD: assert property ($fell(wake_request) |-> $past(wake_clr))
      else $error("wake dropped without clear");
   AST_WAKE_RUN: assert property ($rose(wake_request) |-> run_r < 4'h5)
      else $error("wake while clock runs");
   AST_SLVERR: assert property (acc |-> pslverr == !mapped)
      else $error("slave error wrong");
   AST_PRDATA_HI: assert property (prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_SW_READ: assert property (rd && paddr == 8'h08 |-> prdata[7:1] == 7'h0)
      else $error("unused bits read nonzero");
   AST_TX9_WO: assert property (rd && paddr == 8'h00 |-> !prdata[0])
      else $error("write-only bit read back");
   AST_TX_OE: assert property ($fell(transmit_pin_oe_n) |-> $past(wr))
      else $error("transmit pin driven without write");
   AST_RS_OE: assert property ($fell(receive_shared_pin_oe_n) |-> $past(wr))
      else $error("shared pin driven without write");
endmodule : uart_regs_sva

bind uart_control_and_data_regs uart_regs_sva uart_regs_sva_i (.*);

/* verif/remote_node.sv */
// Remote serial node at 16 clocks a bit
module remote_node (
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic tx_line,
   output logic rx_line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rx_line = 1'b1;
   task automatic send(input logic [10:0] bits, input int n);
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rx_line <= bits[i];
         repeat (16) @(posedge clk);
      end
      rx_line <= 1'b1;
   endtask : send
   // Start taken at the falling edge, bits sampled mid-bit
   task automatic recv(input int n, output logic [11:0] bits, output int t0);
      int w;
      bits = 12'hfff;
      w = 0;
      while (tx_line !== 1'b0 && w < 2000) begin
         @(posedge clk);
         w++;
      end
      t0 = int'($time);
      for (int i = 0; i < n; i++) begin
         repeat (i == 0 ? 8 : 16) @(posedge clk);
         bits[i] = tx_line;
      end
   endtask : recv
endmodule : remote_node

/* verif/uart_control_and_data_regs_tb_top.sv */
// Self-checking bench of the serial unit
module uart_control_and_data_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a, d, m, x; logic e;} row_s;
   logic clk, nrst, psel, penable, pwrite, stopped, e, pready, pslverr;
   logic tx_out, tx_oe_n, rs_out, rs_oe_n, irq, wake, node_rx;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [11:0] b0, b1, xb, mk;
   int err_count, samples_checked, t0, t1, n;
   wire logic tx_wire = tx_oe_n ? 1'b1 : tx_out;
   wire logic rx_wire = rs_oe_n ? node_rx : rs_out;
   row_s rows[6] = '{'{8'h04, 8'h3f, 8'hff, 8'h3f, 1'b0}, '{8'h04, 8'hc0, 8'hff, 8'h00, 1'b0},
      '{8'h08, 8'hff, 8'hff, 8'h01, 1'b0}, '{8'h00, 8'h7f, 8'hfd, 8'h78, 1'b0},
      '{8'h14, 8'h5a, 8'hff, 8'h5a, 1'b0}, '{8'h1c, 8'hff, 8'hff, 8'h00, 1'b1}};
   logic [7:0] fmts[3] = '{8'h80, 8'ha8, 8'hf1};
   uart_control_and_data_regs uart_control_and_data_regs_i (.clk(clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .uart_clock_stopped(stopped),
      .transmit_pin_out(tx_out), .transmit_pin_oe_n(tx_oe_n), .receive_shared_pin_in(rx_wire),
      .receive_shared_pin_out(rs_out), .receive_shared_pin_oe_n(rs_oe_n),
      .serial_interrupt_request(irq), .wake_request(wake));
   remote_node remote_node_i (.clk(clk), .tx_line(tx_wire), .rx_line(node_rx));
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", s, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Expected line bits, start first
   function automatic int frame(input logic [7:0] f, input logic [7:0] d, output logic [11:0] b);
      int k;
      logic p;
      b = {3'b111, d, 1'b0};
      k = 9;
      p = ^d ^ f[4];
      if (f[6]) begin
         b[k] = f[0];
         p = p ^ f[0];
         k++;
      end
      if (f[5]) begin
         b[k] = p;
         k++;
      end
      return f[3] ? k + 2 : k + 1;
   endfunction : frame
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      summarize();
   end
   initial begin
      {nrst, psel, penable, pwrite, stopped} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      apb(0, 8'h10, 8'h00);
      chk("status reset", 32'h0b, r);
      foreach (rows[i]) begin
         apb(1, rows[i].a, rows[i].d);
         chk("slverr", {31'h0, rows[i].e}, {31'h0, e});
         apb(0, rows[i].a, 8'h00);
         chk("readback", {24'h0, rows[i].x}, r & {24'h0, rows[i].m});
      end
      apb(1, 8'h08, 8'h00);
      apb(1, 8'h18, 8'h10);
      apb(1, 8'h14, 8'h00);
      foreach (fmts[i]) begin
         apb(1, 8'h00, fmts[i]);
         apb(1, 8'h04, 8'he4);
         n = frame(fmts[i], 8'h5b, xb);
         mk = 12'((1 << n) - 1);
         fork
            begin
               remote_node_i.recv(n, b0, t0);
               remote_node_i.recv(n, b1, t1);
            end
            begin
               apb(1, 8'h0c, 8'h5b);
               apb(1, 8'h0c, 8'h5b);
            end
         join
         chk("frame", 32'(xb & mk), 32'(b0 & mk));
         chk("frame2", 32'(xb & mk), 32'(b1 & mk));
         chk("gap", 1, 32'(t1 - t0 >= n * 1600 && t1 - t0 <= n * 1600 + 300));
      end
      apb(1, 8'h00, 8'h80);
      apb(1, 8'h04, 8'hf4);
      apb(1, 8'h18, 8'h11);
      remote_node_i.send({2'b11, 8'h35, 1'b0}, 10);
      apb(0, 8'h10, 8'h00);
      @(negedge clk);
      chk("dropped", 32'h0, r & 32'h4 | {31'h0, irq});
      remote_node_i.send({2'b11, 8'ha5, 1'b0}, 10);
      @(negedge clk);
      chk("addr irq", 32'h1, {31'h0, irq});
      apb(0, 8'h10, 8'h00);
      chk("avail", 32'h4, r & 32'h4);
      apb(0, 8'h0c, 8'h00);
      chk("rx data", 32'ha5, r);
      @(negedge clk);
      chk("irq held", 32'h1, {31'h0, irq});
      apb(1, 8'h18, 8'h11);
      @(negedge clk);
      chk("irq clear", 32'h0, {31'h0, irq});
      apb(1, 8'h08, 8'h01);
      @(negedge clk);
      chk("wire both", 32'h1, {31'h0, rs_oe_n});
      apb(1, 8'h04, 8'h80);
      @(negedge clk);
      chk("wire tx", 32'h2, {30'h0, tx_oe_n, rs_oe_n});
      apb(1, 8'h08, 8'h00);
      apb(1, 8'h04, 8'he4);
      apb(1, 8'h0c, 8'h55);
      apb(1, 8'h0c, 8'h66);
      repeat (40) @(posedge clk);
      apb(1, 8'h00, 8'h00);
      @(negedge clk);
      chk("off float", 32'h1, {31'h0, tx_oe_n});
      apb(0, 8'h04, 8'h00);
      chk("off ctrl", 32'h24, r);
      apb(0, 8'h10, 8'h00);
      chk("off status", 32'h0b, r);
      apb(1, 8'h00, 8'h80);
      apb(1, 8'h04, 8'he4);
      fork
         remote_node_i.recv(10, b0, t0);
         apb(1, 8'h0c, 8'h3c);
      join
      chk("fresh", 32'h3c, 32'(b0[8:1]));
      apb(1, 8'h04, 8'hc4);
      apb(1, 8'h00, 8'h84);
      while (tx_wire !== 1'b0 && n < 900) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      fork
         while (tx_wire === 1'b0 && n < 1200) begin
            @(posedge clk);
            n++;
         end
         begin
            repeat (30) @(posedge clk);
            apb(1, 8'h00, 8'h80);
         end
      join
      chk("break", 1, 32'(n >= 828 && n <= 900));
      apb(1, 8'h04, 8'h08);
      remote_node_i.send(11'h0, 1);
      @(negedge clk);
      chk("no wake", 32'h0, {31'h0, wake});
      @(posedge clk);
      stopped <= 1'b1;
      remote_node_i.send(11'h0, 1);
      @(negedge clk);
      chk("wake", 32'h1, {31'h0, wake});
      apb(1, 8'h18, 8'h12);
      @(negedge clk);
      chk("wake clear", 32'h0, {31'h0, wake});
      summarize();
   end
endmodule : uart_control_and_data_regs_tb_top
